// [hdl/gch_control.sv]
// Gauge control command handler: subcommands, status word, power wake
`timescale 1ns/1ps
`default_nettype none
module gch_control
  import gch_pkg::*;
#(
  parameter int          SETTLE_CYC    = gch_pkg::OSC_SETTLE_CYC,
  parameter int          CHEM_WORDS    = 64,
  parameter logic [15:0] DEVICE_TYPE   = 16'h5a01, // Arbitrary value
  parameter logic [15:0] FIRMWARE_REV  = 16'h0101, // Arbitrary value
  parameter logic [15:0] SILICON_REV   = 16'h0011, // Arbitrary value
  parameter logic [15:0] CHEMISTRY_ID  = 16'h0123, // Arbitrary value
  parameter logic [15:0] FLASH_REV     = 16'h0001  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Host command port
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output var  logic [7:0]  cmd_rdata_q,
  output var  logic        cmd_rvalid_q,
  // Link and power
  input  wire logic        link_single_wire,
  input  wire logic        comm_activity,
  input  wire logic        sleep_state,
  output var  logic        osc_enable_q,
  output var  logic        clock_stretch_q,
  // Gauge core status
  input  wire logic        load_model_flag,
  input  wire logic        resistance_update_off_flag,
  input  wire logic        voltage_suitable,
  input  wire logic [6:0]  charge_percentage,
  input  wire logic        cap_update,
  input  wire logic        res_update,
  input  wire logic        cycle_tally_inc,
  input  wire logic [6:0]  error_limit,
  output var  logic        accuracy_update_needed_flag,
  output var  logic [7:0]  tracking_update_state_q,
  // Calibration
  input  wire logic        board_cal_done,
  input  wire logic        counter_cal_done,
  output var  logic        board_cal_start_q,
  output var  logic        counter_cal_start_q,
  output var  logic        counter_offset_store_q,
  output var  logic        offset_cal_start_q,
  output var  logic        cal_mode_q,
  output var  logic        full_reset_q,
  // Chemistry table
  input  wire logic [15:0] chem_rd_data,
  input  wire logic [14:0] chem_stored_sum,
  output var  logic [7:0]  chem_rd_addr_q
);

  gch_pwr_e    pwr_q;
  gch_cks_e    cks_q;
  logic [31:0] settle_cnt_q;
  logic        sleep_prev_q;
  logic        pend_q, pend_wr_q;
  logic [7:0]  pend_addr_q, pend_data_q;
  logic [7:0]  sub_lo_q;
  logic [15:0] result_q, last_sub_q, reset_cnt_q, sum_q;
  logic        show_status_q;
  logic        lock_q, cal_allowed_q, cal_active_q, cca_q, bca_q, csv_q;
  logic        deep_flag_q, vok_q, qen_q;
  logic [6:0]  margin;

  // Request source: live port when running, or a request held over wake
  wire logic live_ok  = (pwr_q == GCH_PW_RUN) && !pend_q;
  wire logic op_wr    = live_ok ? cmd_wr : (pend_q && pwr_q == GCH_PW_RUN && pend_wr_q);
  wire logic op_rd    = live_ok ? cmd_rd : (pend_q && pwr_q == GCH_PW_RUN && !pend_wr_q);
  wire logic [7:0] op_addr  = live_ok ? cmd_addr : pend_addr_q;
  wire logic [7:0] op_wdata = live_ok ? cmd_wdata : pend_data_q;

  // Wake and sleep events
  wire logic any_comm  = cmd_wr | cmd_rd | comm_activity;
  wire logic wake_evt  = (pwr_q == GCH_PW_DEEP) && any_comm;
  wire logic sleep_rise = sleep_state && !sleep_prev_q;
  wire logic go_deep   = (pwr_q == GCH_PW_RUN) && deep_flag_q && sleep_rise;
  wire logic settled   = (pwr_q == GCH_PW_SETTLE) && (settle_cnt_q == 32'(SETTLE_CYC - 1));

  // Subcommand decode; the high byte write completes the word
  wire logic        exec    = op_wr && (op_addr == CMD_CONTROL_HI);
  wire logic [15:0] sub     = {op_wdata, sub_lo_q};
  wire logic        blocked = lock_q && (sub >= LOCK_RESTRICT_FLOOR);
  wire logic        ok      = exec && !blocked;
  wire logic is_status  = ok && sub == SUB_STATUS_QUERY;
  wire logic is_board   = ok && sub == SUB_BOARD_CALIBRATE;
  wire logic is_counter = ok && sub == SUB_COUNTER_CALIBRATE;
  wire logic is_store   = ok && sub == SUB_COUNTER_STORE;
  wire logic is_arm     = ok && sub == SUB_ARM_DEEP_SLEEP;
  wire logic is_chk     = ok && sub == SUB_CHEMISTRY_SUM && cks_q == GCH_CK_IDLE;
  wire logic is_lock    = ok && sub == SUB_LOCK;
  wire logic is_track   = ok && sub == SUB_TRACKING_START;
  wire logic is_caltog  = ok && sub == SUB_CAL_ENABLE_TOGGLE;
  wire logic is_reset   = ok && sub == SUB_FULL_RESET;
  wire logic is_calexit = ok && sub == SUB_CAL_EXIT;
  wire logic is_calent  = ok && sub == SUB_CAL_ENTER && cal_allowed_q;
  wire logic is_offcal  = ok && sub == SUB_OFFSET_CAL && cal_active_q;

  // Word returned by reporting subcommands
  wire logic rep_load =
    ok && (sub == SUB_DEVICE_TYPE_QUERY || sub == SUB_FIRMWARE_REV_QUERY ||
           sub == SUB_SILICON_REV_QUERY || sub == SUB_RESET_COUNT_QUERY ||
           sub == SUB_LAST_SUB_QUERY || sub == SUB_CHEMISTRY_QUERY ||
           sub == SUB_FLASH_REV_QUERY);
  wire logic [15:0] rep_val =
    (sub == SUB_DEVICE_TYPE_QUERY)  ? DEVICE_TYPE :
    (sub == SUB_FIRMWARE_REV_QUERY) ? FIRMWARE_REV :
    (sub == SUB_SILICON_REV_QUERY)  ? SILICON_REV :
    (sub == SUB_RESET_COUNT_QUERY)  ? reset_cnt_q :
    (sub == SUB_LAST_SUB_QUERY)     ? last_sub_q :
    (sub == SUB_CHEMISTRY_QUERY)    ? CHEMISTRY_ID : FLASH_REV;

  // Checksum result: 15-bit sum, top bit set on mismatch
  wire logic        chk_done  = (cks_q == GCH_CK_DONE);
  wire logic [14:0] chk_sum   = sum_q[14:0];
  wire logic        chk_fail  = (chk_sum != chem_stored_sum);
  wire logic        chk_last  = (chem_rd_addr_q == 8'(CHEM_WORDS - 1));

  // Live status word; reserved bits read zero
  logic [15:0] status_word;
  always_comb begin
    status_word                      = 16'h0000;
    status_word[ST_FULL_ACCESS_LOCK] = 1'b0;
    status_word[ST_LOCKED]           = lock_q;
    status_word[ST_CAL_ACTIVE]       = cal_active_q;
    status_word[ST_COUNTER_CAL]      = cca_q;
    status_word[ST_BOARD_CAL]        = bca_q;
    status_word[ST_CHECKSUM_VALID]   = csv_q;
    status_word[ST_DEEP_SLEEP]       = deep_flag_q;
    status_word[ST_SLEEP]            = sleep_state;
    status_word[ST_LOAD_MODEL]       = load_model_flag;
    status_word[ST_RES_UPDATE_OFF]   = resistance_update_off_flag;
    status_word[ST_VOLTAGE_OK]       = vok_q;
    status_word[ST_CAP_UPDATE_EN]    = qen_q;
  end

  // Read data selection by command code; unmapped codes read zero
  wire logic [15:0] ctl_word = show_status_q ? status_word : result_q;
  wire logic [7:0]  rd_byte =
    (op_addr == CMD_CONTROL_LO)   ? ctl_word[7:0] :
    (op_addr == CMD_CONTROL_HI)   ? ctl_word[15:8] :
    (op_addr == CMD_CHARGE_PCT)   ? {1'b0, charge_percentage} :
    (op_addr == CMD_ERROR_MARGIN) ? {1'b0, margin} : 8'h00;

  // Error margin and condition flag
  gch_error_margin u_margin (
    .clock       (clock),
    .rst         (rst),
    .full_reset  (is_reset),
    .cap_update  (cap_update),
    .res_update  (res_update),
    .cycle_inc   (cycle_tally_inc),
    .error_limit (error_limit),
    .margin_q    (margin),
    .steps_q     (),
    .cond_flag_q (accuracy_update_needed_flag)
  );

  // Oscillator power: stopped in deep sleep, restarted on any traffic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_q        <= GCH_PW_RUN;
      settle_cnt_q <= 32'h0;
      sleep_prev_q <= 1'b0;
    end else begin
      sleep_prev_q <= sleep_state;
      case (pwr_q)
        GCH_PW_RUN: begin
          if (go_deep) begin
            pwr_q <= GCH_PW_DEEP;
          end
        end
        GCH_PW_DEEP: begin
          if (wake_evt) begin
            pwr_q        <= GCH_PW_SETTLE;
            settle_cnt_q <= 32'h0;
          end
        end
        GCH_PW_SETTLE: begin
          settle_cnt_q <= settle_cnt_q + 32'h1;
          if (settled) begin
            pwr_q <= GCH_PW_RUN;
          end
        end
        default: pwr_q <= GCH_PW_RUN;
      endcase
    end
  end

  // Oscillator enable and stretch come from flops so they are glitch free
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_enable_q    <= 1'b1;
      clock_stretch_q <= 1'b0;
    end else begin
      osc_enable_q    <= !go_deep && (pwr_q != GCH_PW_DEEP || wake_evt);
      clock_stretch_q <= (pwr_q == GCH_PW_DEEP) ? (wake_evt && !link_single_wire) :
                         (pwr_q == GCH_PW_SETTLE) ? !settled : 1'b0;
    end
  end

  // Request caught in deep sleep: single-wire loses it, two-wire holds it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q      <= 1'b0;
      pend_wr_q   <= 1'b0;
      pend_addr_q <= 8'h00;
      pend_data_q <= 8'h00;
    end else if (wake_evt && (cmd_wr || cmd_rd) && !link_single_wire) begin
      pend_q      <= 1'b1;
      pend_wr_q   <= cmd_wr;
      pend_addr_q <= cmd_addr;
      pend_data_q <= cmd_wdata;
    end else if (pwr_q == GCH_PW_RUN) begin
      pend_q <= 1'b0;
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_rdata_q  <= 8'h00;
      cmd_rvalid_q <= 1'b0;
    end else begin
      cmd_rvalid_q <= op_rd;
      if (op_rd) begin
        cmd_rdata_q <= rd_byte;
      end
    end
  end

  // Subcommand words: low byte, result, previous code and reset tally
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sub_lo_q      <= 8'h00;
      result_q      <= 16'h0000;
      show_status_q <= 1'b1;
      last_sub_q    <= 16'h0000;
      reset_cnt_q   <= 16'h0000;
    end else begin
      if (op_wr && op_addr == CMD_CONTROL_LO) begin
        sub_lo_q <= op_wdata;
      end
      if (exec) begin
        last_sub_q <= sub & LAST_SUB_MASK;
      end
      if (is_reset) begin
        reset_cnt_q <= reset_cnt_q + 16'h0001;
      end
      if (chk_done) begin
        result_q      <= {chk_fail, chk_sum};
        show_status_q <= 1'b0;
      end else if (rep_load) begin
        result_q      <= rep_val;
        show_status_q <= 1'b0;
      end else if (is_status) begin
        show_status_q <= 1'b1;
      end
    end
  end

  // Chemistry sum walks the table one word per cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cks_q          <= GCH_CK_IDLE;
      sum_q          <= 16'h0000;
      chem_rd_addr_q <= 8'h00;
    end else begin
      case (cks_q)
        GCH_CK_IDLE: begin
          if (is_chk) begin
            cks_q          <= GCH_CK_SUM;
            sum_q          <= 16'h0000;
            chem_rd_addr_q <= 8'h00;
          end
        end
        GCH_CK_SUM: begin
          sum_q <= sum_q + chem_rd_data;
          if (chk_last) begin
            cks_q <= GCH_CK_DONE;
          end else begin
            chem_rd_addr_q <= chem_rd_addr_q + 8'h01;
          end
        end
        default: cks_q <= GCH_CK_IDLE;
      endcase
    end
  end

  // Access and calibration flags; subcommand and checksum sets win over clears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_q        <= 1'b0;
      cal_allowed_q <= 1'b0;
      cal_active_q  <= 1'b0;
      bca_q         <= 1'b0;
      cca_q         <= 1'b0;
      csv_q         <= 1'b0;
    end else begin
      lock_q        <= lock_q | is_lock;
      cal_allowed_q <= is_reset ? 1'b0 : (cal_allowed_q ^ is_caltog);
      cal_active_q  <= is_calent | (cal_active_q & !is_calexit & !is_reset);
      bca_q         <= is_board | (bca_q & !board_cal_done & !is_reset);
      cca_q         <= is_counter | is_offcal | (cca_q & !counter_cal_done & !is_reset);
      csv_q         <= chk_done ? !chk_fail : (csv_q & !is_reset);
    end
  end

  // Sleep arming and capacity tracking flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      deep_flag_q             <= 1'b0;
      vok_q                   <= 1'b0;
      qen_q                   <= 1'b0;
      tracking_update_state_q <= 8'h00;
    end else begin
      deep_flag_q <= is_arm | (deep_flag_q & !wake_evt & !is_reset);
      vok_q       <= is_track | (vok_q & voltage_suitable);
      qen_q       <= qen_q | is_track;
      if (is_track) begin
        tracking_update_state_q[TUS_TRACKING_BIT] <= 1'b1;
      end
    end
  end

  // One-cycle command pulses toward the gauge core, except cal_mode_q which is a level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      board_cal_start_q      <= 1'b0;
      counter_cal_start_q    <= 1'b0;
      counter_offset_store_q <= 1'b0;
      offset_cal_start_q     <= 1'b0;
      cal_mode_q             <= 1'b0;
      full_reset_q           <= 1'b0;
    end else begin
      board_cal_start_q      <= is_board;
      counter_cal_start_q    <= is_counter;
      counter_offset_store_q <= is_store;
      offset_cal_start_q     <= is_offcal;
      cal_mode_q             <= is_calent | (cal_mode_q & !is_calexit & !is_reset);
      full_reset_q           <= is_reset;
    end
  end

endmodule
`default_nettype wire

// [hdl/gch_error_margin.sv]
// Error margin tracker with condition flag hysteresis
`timescale 1ns/1ps
`default_nettype none
module gch_error_margin
  import gch_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Events
  input  wire logic        full_reset,
  input  wire logic        cap_update,
  input  wire logic        res_update,
  input  wire logic        cycle_inc,
  // Threshold and results
  input  wire logic [6:0]  error_limit,
  output var  logic [6:0]  margin_q,
  output var  logic [10:0] steps_q,
  output var  logic        cond_flag_q
);

  logic        since_cap_q;
  wire  logic  any_upd  = cap_update | res_update;
  wire  logic [6:0] upd_val = (cap_update & res_update) ? ERR_BOTH_UPD :
                              cap_update ? ERR_CAP_UPD : ERR_RES_UPD;

  // Reported margin: reset wins, then updates, then one percent per cycle step
  wire logic [6:0] margin_d =
    full_reset ? ERR_FULL_RESET :
    any_upd    ? upd_val :
    (cycle_inc && margin_q < ERR_MAX) ? margin_q + 7'h01 : margin_q;

  // Internal margin moves in 0.05 percent steps only after a capacity update
  wire logic [10:0] steps_max = gch_pct_to_steps(ERR_MAX);
  wire logic [10:0] steps_d =
    full_reset ? gch_pct_to_steps(ERR_FULL_RESET) :
    any_upd    ? gch_pct_to_steps(upd_val) :
    (cycle_inc && since_cap_q && steps_q < steps_max) ? steps_q + 11'h001 : steps_q;

  // Flag sets above the limit, clears only below it; equal holds
  wire logic cond_d = (margin_q > error_limit) ? 1'b1 :
                      (margin_q < error_limit) ? 1'b0 : cond_flag_q;

  // State registers; margin starts as after a full reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      margin_q    <= ERR_FULL_RESET;
      steps_q     <= 11'h7d0;
      since_cap_q <= 1'b0;
      cond_flag_q <= 1'b0;
    end else begin
      margin_q    <= margin_d;
      steps_q     <= steps_d;
      since_cap_q <= full_reset ? 1'b0 : (cap_update | since_cap_q);
      cond_flag_q <= cond_d;
    end
  end

endmodule
`default_nettype wire

// [hdl/gch_pkg.sv]
// Shared constants and types for the gauge control subcommand handler
package gch_pkg;

  // Host command codes (byte addresses of the command space)
  localparam logic [7:0] CMD_CONTROL_LO   = 8'h00;
  localparam logic [7:0] CMD_CONTROL_HI   = 8'h01;
  localparam logic [7:0] CMD_CHARGE_PCT   = 8'h02;
  localparam logic [7:0] CMD_ERROR_MARGIN = 8'h03;

  // Control subcommands
  localparam logic [15:0] SUB_STATUS_QUERY       = 16'h0000;
  localparam logic [15:0] SUB_DEVICE_TYPE_QUERY  = 16'h0001;
  localparam logic [15:0] SUB_FIRMWARE_REV_QUERY = 16'h0002;
  localparam logic [15:0] SUB_SILICON_REV_QUERY  = 16'h0003;
  localparam logic [15:0] SUB_RESET_COUNT_QUERY  = 16'h0005;
  localparam logic [15:0] SUB_LAST_SUB_QUERY     = 16'h0007;
  localparam logic [15:0] SUB_CHEMISTRY_QUERY    = 16'h0008;
  localparam logic [15:0] SUB_BOARD_CALIBRATE    = 16'h0009;
  localparam logic [15:0] SUB_COUNTER_CALIBRATE  = 16'h000a;
  localparam logic [15:0] SUB_COUNTER_STORE      = 16'h000b;
  localparam logic [15:0] SUB_FLASH_REV_QUERY    = 16'h000c;
  localparam logic [15:0] SUB_ARM_DEEP_SLEEP     = 16'h0010;
  localparam logic [15:0] SUB_CHEMISTRY_SUM      = 16'h0017;
  localparam logic [15:0] SUB_LOCK               = 16'h0020;
  localparam logic [15:0] SUB_TRACKING_START     = 16'h0021;
  localparam logic [15:0] SUB_CAL_ENABLE_TOGGLE  = 16'h002d;
  localparam logic [15:0] SUB_FULL_RESET         = 16'h0041;
  localparam logic [15:0] SUB_CAL_EXIT           = 16'h0080;
  localparam logic [15:0] SUB_CAL_ENTER          = 16'h0081;
  localparam logic [15:0] SUB_OFFSET_CAL         = 16'h0082;

  // Subcommands at or above this code need the unlocked state
  localparam logic [15:0] LOCK_RESTRICT_FLOOR = 16'h0020;
  // Recorded previous subcommand is kept below 0x0020
  localparam logic [15:0] LAST_SUB_MASK       = 16'h001f;

  // Status word bit positions, high byte
  localparam int ST_FULL_ACCESS_LOCK = 14;
  localparam int ST_LOCKED           = 13;
  localparam int ST_CAL_ACTIVE       = 12;
  localparam int ST_COUNTER_CAL      = 11;
  localparam int ST_BOARD_CAL        = 10;
  localparam int ST_CHECKSUM_VALID   = 9;
  // Status word bit positions, low byte
  localparam int ST_DEEP_SLEEP       = 5;
  localparam int ST_SLEEP            = 4;
  localparam int ST_LOAD_MODEL       = 3;
  localparam int ST_RES_UPDATE_OFF   = 2;
  localparam int ST_VOLTAGE_OK       = 1;
  localparam int ST_CAP_UPDATE_EN    = 0;

  // Tracking update state bit set by tracking start
  localparam int TUS_TRACKING_BIT = 2;

  // Error margin settings, in whole percent
  localparam logic [6:0] ERR_FULL_RESET = 7'h64;
  localparam logic [6:0] ERR_BOTH_UPD   = 7'h01;
  localparam logic [6:0] ERR_CAP_UPD    = 7'h03;
  localparam logic [6:0] ERR_RES_UPD    = 7'h05;
  localparam logic [6:0] ERR_MAX        = 7'h64;

  // Oscillator restart time after deep sleep
  localparam int CLK_FREQ_MHZ   = 50;
  localparam int OSC_SETTLE_US  = 6000;
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_FREQ_MHZ;

  // Power state of the communication oscillator
  typedef enum logic [1:0] {
    GCH_PW_RUN    = 2'b00,
    GCH_PW_DEEP   = 2'b01,
    GCH_PW_SETTLE = 2'b10
  } gch_pwr_e;

  // Chemistry checksum sequencer
  typedef enum logic [1:0] {
    GCH_CK_IDLE = 2'b00,
    GCH_CK_SUM  = 2'b01,
    GCH_CK_DONE = 2'b10
  } gch_cks_e;

  // Whole percent to internal 0.05 percent steps (times twenty)
  function automatic logic [10:0] gch_pct_to_steps(input logic [6:0] pct);
    gch_pct_to_steps = {pct, 4'h0} + {2'h0, pct, 2'h0};
  endfunction

endpackage

// [verification/gauge_control_subcommand_handler_test.sv]
// Directed test of the gauge control command handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", n, e, a); end end
module gauge_control_subcommand_handler_test;
  import gch_pkg::*;
  logic clock = '0, rst = '1, cmd_wr = '0, cmd_rd = '0, link_single_wire = '0, comm_activity = '0;
  logic sleep_state = '0, load_model_flag = '1, resistance_update_off_flag = '1, voltage_suitable = '1;
  logic cap_update = '0, res_update = '0, cycle_tally_inc = '0, board_cal_done, counter_cal_done;
  logic cmd_rvalid_q, osc_enable_q, clock_stretch_q, accuracy_update_needed_flag, board_cal_start_q;
  logic counter_cal_start_q, counter_offset_store_q, offset_cal_start_q, cal_mode_q, full_reset_q;
  logic [7:0]  cmd_addr = '0, cmd_wdata = '0, cmd_rdata_q, tracking_update_state_q, chem_rd_addr_q, b;
  logic [6:0]  charge_percentage = 7'h39, error_limit = 7'h02;
  logic [14:0] chem_stored_sum = 15'h000a;
  logic [15:0] chem_rd_data, w, n;
  logic [15:0] ids[5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h000c};
  logic [15:0] idv[5] = '{16'h1a2b, 16'h0203, 16'h0405, 16'h0607, 16'h0809};
  logic [2:0]  evs[5] = '{3'h4, 3'h2, 3'h6, 3'h1, 3'h1};
  logic [7:0]  mgs[5] = '{8'h03, 8'h05, 8'h01, 8'h02, 8'h03};
  int checked = 0, n_mismatch = 0;
  // Short settle and table so the run stays brief; identity words arbitrary
  gch_control #(.SETTLE_CYC(8), .CHEM_WORDS(4), .DEVICE_TYPE(16'h1a2b), .FIRMWARE_REV(16'h0203),
    .SILICON_REV(16'h0405), .CHEMISTRY_ID(16'h0607), .FLASH_REV(16'h0809)) gch_control_inst (.*);
  gch_core_model gch_core_model_inst (.*);
  initial forever #10 clock = ~clock;
  // Host byte transfers; each ends one edge after release
  task automatic wr(input logic [7:0] a, d);
    {cmd_wr, cmd_addr, cmd_wdata} <= {1'h1, a, d};
    @(posedge clock) cmd_wr <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    {cmd_rd, cmd_addr} <= {1'h1, a};
    @(posedge clock) cmd_rd <= 1'h0;
    #1 d = cmd_rdata_q;
    `CHK("rvalid", 1'h1, cmd_rvalid_q)
    @(posedge clock);
  endtask
  task automatic get(output logic [15:0] r);
    rd(8'h00, r[7:0]);
    rd(8'h01, r[15:8]);
  endtask
  task automatic ask(input logic [15:0] c, output logic [15:0] r);
    wr(8'h00, c[7:0]);
    wr(8'h01, c[15:8]);
    get(r);
  endtask
  task automatic ev(input logic [2:0] m);
    {cap_update, res_update, cycle_tally_inc} <= m;
    @(posedge clock) {cap_update, res_update, cycle_tally_inc} <= 3'h0;
    @(posedge clock);
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    ask(SUB_STATUS_QUERY, w);
    `CHK("status", 16'h000c, w)
    foreach (ids[i]) begin
      ask(ids[i], w);
      `CHK("ident", idv[i], w)
    end
    ask(SUB_LAST_SUB_QUERY, w);
    `CHK("last", 16'h000c, w)
    ask(SUB_RESET_COUNT_QUERY, n);
    ask(SUB_FULL_RESET, w);
    ask(SUB_RESET_COUNT_QUERY, w);
    `CHK("resets", n + 16'h0001, w)
    rd(CMD_ERROR_MARGIN, b);
    `CHK("margin", 8'h64, b)
    // Update events set the margin, tally steps raise it; flag follows the limit
    foreach (evs[i]) begin
      ev(evs[i]);
      rd(CMD_ERROR_MARGIN, b);
      `CHK("margin", mgs[i], b)
      `CHK("cond", 5'b10011 >> i & 5'h1, {4'h0, accuracy_update_needed_flag})
    end
    rd(CMD_CHARGE_PCT, b);
    `CHK("charge", 8'h39, b)
    for (int i = 0; i < 2; i++) begin
      ask(16'(SUB_BOARD_CALIBRATE + i), w);
      ask(SUB_STATUS_QUERY, w);
      `CHK("cal busy", 1'h1, w[10 + i])
      repeat (25) @(posedge clock);
      ask(SUB_STATUS_QUERY, w);
      `CHK("cal done", 1'h0, w[10 + i])
    end
    ask(SUB_COUNTER_STORE, w);
    for (int i = 0; i < 2; i++) begin
      chem_stored_sum <= 15'(15'h000a + i);
      ask(SUB_CHEMISTRY_SUM, w);
      repeat (10) @(posedge clock);
      get(w);
      `CHK("sum", {i[0], 15'h000a}, w)
      ask(SUB_STATUS_QUERY, w);
      `CHK("sum ok", ~i[0], w[9])
    end
    ask(SUB_ARM_DEEP_SLEEP, w);
    ask(SUB_STATUS_QUERY, w);
    `CHK("deep", 1'h1, w[5])
    sleep_state <= 1'h1;
    repeat (4) @(posedge clock);
    `CHK("osc", 1'h0, osc_enable_q)
    comm_activity <= 1'h1;
    @(posedge clock) comm_activity <= 1'h0;
    repeat (2) @(posedge clock);
    #1 `CHK("stretch", 1'h1, clock_stretch_q)
    repeat (12) @(posedge clock);
    ask(SUB_STATUS_QUERY, w);
    `CHK("woken", 2'h1, w[5:4])
    sleep_state <= 1'h0;
    // Low byte sent in deep sleep: two-wire holds and runs it, single-wire loses it
    for (int i = 0; i < 2; i++) begin
      link_single_wire <= i[0];
      ask(SUB_ARM_DEEP_SLEEP, w);
      sleep_state <= 1'h1;
      repeat (2) @(posedge clock);
      wr(CMD_CONTROL_LO, i[0] ? 8'h02 : 8'h05);
      repeat (12) @(posedge clock);
      sleep_state <= 1'h0;
      wr(CMD_CONTROL_HI, 8'h00);
      get(w);
      `CHK("wake request", n + 16'h0001, w)
    end
    link_single_wire <= 1'h0;
    ask(SUB_CAL_ENABLE_TOGGLE, w);
    ask(SUB_CAL_ENTER, w);
    `CHK("cal mode", 1'h1, cal_mode_q)
    ask(SUB_OFFSET_CAL, w);
    ask(SUB_CAL_EXIT, w);
    `CHK("cal mode", 1'h0, cal_mode_q)
    ask(SUB_TRACKING_START, w);
    ask(SUB_STATUS_QUERY, w);
    `CHK("tracking", 3'h7, {tracking_update_state_q[2], w[1:0]})
    voltage_suitable <= 1'h0;
    ask(SUB_STATUS_QUERY, w);
    `CHK("volt", 2'h1, w[1:0])
    ask(SUB_LOCK, w);
    ask(SUB_FULL_RESET, w);
    ask(SUB_RESET_COUNT_QUERY, w);
    `CHK("locked reset", n + 16'h0001, w)
    load_model_flag <= 1'h0;
    ask(SUB_STATUS_QUERY, w);
    `CHK("locked", 1'h1, w[13])
    `CHK("model", 1'h0, w[3])
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire

// [verification/gch_control_checker.sv]
// Port checks for the gauge control command handler
`timescale 1ns/1ps
`default_nettype none
module gch_control_checker (
  // Clock, reset, host port
  input wire logic       clock, rst, cmd_wr, cmd_rd, cmd_rvalid_q, sleep_state,
  input wire logic [7:0] cmd_addr, cmd_wdata, cmd_rdata_q, tracking_update_state_q,
  // Power and event outputs
  input wire logic       osc_enable_q, clock_stretch_q, board_cal_start_q, counter_cal_start_q,
  input wire logic       counter_offset_store_q, offset_cal_start_q, full_reset_q
);
  logic       exec_q;
  logic [1:0] st_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Zero high byte just run; a held request runs as the stretch ends, so keep history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exec_q <= 1'h0;
      st_q   <= 2'h0;
    end else begin
      exec_q <= (cmd_wr && cmd_addr == 8'h01 && cmd_wdata == 8'h00) || st_q != 2'h0;
      st_q   <= {st_q[0], clock_stretch_q};
    end
  end
  sequence one_shot(s);
    s ##1 !s;
  endsequence
  AST_RVALID_CAUSE: assert property (cmd_rvalid_q |-> $past(cmd_rd) || st_q != 2'h0)
    else $error("answer without read");
  AST_RDATA_HOLD: assert property (!cmd_rvalid_q |-> $stable(cmd_rdata_q))
    else $error("read byte moved");
  AST_BOARD_START: assert property (board_cal_start_q |-> exec_q)
    else $error("stray board start");
  AST_COUNTER_START: assert property (counter_cal_start_q |-> exec_q)
    else $error("stray counter start");
  AST_OFFSET_STORE: assert property (counter_offset_store_q |-> exec_q)
    else $error("stray offset store");
  AST_FULL_RESET: assert property (full_reset_q |-> exec_q ##1 !full_reset_q)
    else $error("bad reset pulse");
  AST_OFFSET_CAL: assert property ($rose(offset_cal_start_q) |-> one_shot(offset_cal_start_q))
    else $error("offset start not one cycle");
  AST_TRACK_BIT: assert property ($rose(tracking_update_state_q[2]) |-> exec_q)
    else $error("stray tracking bit");
  AST_STRETCH_OSC: assert property (clock_stretch_q |-> osc_enable_q)
    else $error("stretch with oscillator off");
  AST_OSC_OFF: assert property ($fell(osc_enable_q) |-> $past(sleep_state))
    else $error("oscillator stopped awake");
endmodule
bind gch_control gch_control_checker gch_control_checker_inst (.*);
`default_nettype wire

// [verification/gch_core_model.sv]
// Gauge core stand-in: calibration completion and chemistry table
`timescale 1ns/1ps
`default_nettype none
module gch_core_model (
  input  wire logic        clock, board_cal_start_q, counter_cal_start_q, offset_cal_start_q,
  input  wire logic [7:0]  chem_rd_addr_q,
  output logic             board_cal_done, counter_cal_done,
  output logic [15:0]      chem_rd_data
);
  logic [4:0] bc_q = 5'h0, cc_q = 5'h0;
  // Word is address plus one, so the sum is easy to predict
  assign chem_rd_data = {8'h00, chem_rd_addr_q} + 16'h0001;
  assign board_cal_done = bc_q == 5'h01;
  assign counter_cal_done = cc_q == 5'h01;
  // Calibrations take 20 cycles, long enough to read the flag while busy
  always_ff @(posedge clock) begin
    bc_q <= board_cal_start_q ? 5'h14 : bc_q - {4'h0, bc_q != 5'h0};
    cc_q <= (counter_cal_start_q || offset_cal_start_q) ? 5'h14 : cc_q - {4'h0, cc_q != 5'h0};
  end
endmodule
`default_nettype wire
